//--- hw/ptp_ts_pkg.sv
/*
 Shared constants and types of the egress/ingress timestamping block.
 Assumes a 100 MHz register/stream clock and a timer supplied by the system.
*/
package ptp_ts_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int OUT_STAGE_CNT = 2;
   localparam logic [15:0] REF_CORR_NS = 16'(CLK_PERIOD_NS * OUT_STAGE_CNT);
   localparam logic [32:0] NS_PER_SEC = 33'h0_3B9A_CA00;

   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_TRIM = 12'h004;
   localparam logic [11:0] REG_STAT = 12'h008;
   localparam int CTRL_ONE_STEP_BIT = 0;
   localparam int CTRL_TC_MODE_BIT = 1;
   localparam logic CTRL_ONE_STEP_RESET = 1'b1;

   localparam int TRIM_W = 11;
   localparam logic [10:0] TRIM_50G_OC = 11'h1C2;
   localparam logic [10:0] TRIM_50G_TC = 11'h225;
   localparam logic [10:0] TRIM_40G_OC = 11'h25D;
   localparam logic [10:0] TRIM_40G_TC = 11'h297;
   localparam logic [10:0] TRIM_40G_WIDE_OC = 11'h26C;
   localparam logic [10:0] TRIM_40G_WIDE_TC = 11'h2D5;

   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_ONE_STEP = 2'h1;
   localparam logic [1:0] OP_TWO_STEP = 2'h2;

   localparam logic [3:0] TOD_FIELD_LEN = 4'hA;
   localparam logic [3:0] CF_FIELD_LEN = 4'h8;
   localparam int FCS_LEN = 4;
   localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;

   typedef struct packed {
      logic valid;
      logic sop;
      logic eop;
      logic [7:0] data;
   } byte_beat_type;

   typedef struct packed {
      logic [1:0] op;
      logic udp_upd;
      logic [7:0] ts_offset;
      logic [7:0] csum_offset;
      logic [15:0] tag;
   } tx_cmd_type;
endpackage

//--- hw/crc32_byte.sv
/*
 One byte step of the reflected Ethernet CRC-32.
 Purely combinational; the caller holds the running value.
*/
`timescale 1ns/1ps
module crc32_byte
   import ptp_ts_pkg::*;
(
   input wire logic [31:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [31:0] crc_out
);
   always_comb
   begin
      logic [31:0] c;
      c = crc_in ^ {24'h0, data_in};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      crc_out = c;
   end
endmodule

//--- hw/ptp_frame_timestamping.sv
/*
 Packet timestamping for a byte-wide egress stream and ingress start markers.
 Assumes the egress source sends each frame without gaps, frames longer than
 the delay line plus the furthest modified byte, and a timer in the pclk domain.
*/
// Operation
// (RL1) Time-of-day timer and stamps: 48-bit seconds, 32-bit nanoseconds.
// (RL2) Correction format: signed 64-bit nanoseconds times 2^16.
// (RL3) External correction timer counts up from zero and wraps at 2^64.
// (RL4) Two-step stamp always corrected to the reference correction plane.
// (RL5) One-step stamp correction set by 11-bit latency trim, default fixed at build.
// (RL6) 50G trim default: 450 ordinary clock, 549 transparent clock.
// (RL7) 40G narrow path trim default: 605 ordinary, 663 transparent.
// (RL8) 40G 256-bit path trim default: 620 ordinary, 725 transparent.
// (RL9) Client gives each frame a command: none, one-step, two-step, checksum flag.
// (RL10) Time-of-day: full 80-bit egress stamp returned to client.
// (RL11) Correction format: 64-bit egress stamp returned, upper bits zero.
// (RL12) Time-of-day one-step: stamp written at commanded byte offset.
// (RL13) Correction one-step: stamp added to field at offset, sum overwrites it.
// (RL14) One-step for raw, UDP/IPv4, UDP/IPv6; two-step for any frame.
// (RL15) One-step UDP checksum updated incrementally per RFC 1624.
// (RL16) Frame check sequence computed after all one-step modifications.
// (RL17) Two-step stamp returned with the client's tag.
// (RL18) Client computes time-of-day checksum with zero stamp bytes.
// (RL19) Client keeps checksum and correction field at the fixed PTP separation.
// (RL20) Ingress stamps every frame without parsing.
// (RL21) Ingress keeps only start-of-packet stamps, 80 bits wide.
// (RL22) Ingress stamp valid only in start cycle with enable high.
// (RL23) Operation code in first cycle; reserved code acts as none.
// (RL24) 16-bit tag output echoes the frame's tag with its stamp.
// (RL25) Transparent mode: timer is a correction value added to the stamp.
// (RL26) Stamp and tag given as one-cycle pulse, in transmission order.
`timescale 1ns/1ps
module ptp_frame_timestamping
   import ptp_ts_pkg::*;
#(
   parameter int DELAY = 32,
   parameter bit TOD_FORMAT = 1'b1,
   parameter bit RATE_50G = 1'b1,
   parameter bit WIDE_256 = 1'b0,
   parameter bit TC_BUILD = 1'b0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [79:0] timer,
   input wire byte_beat_type tx_in,
   input wire tx_cmd_type tx_cmd_in,
   output byte_beat_type tx_out,
   output logic tx_ts_valid,
   output logic [79:0] tx_ts,
   output logic [15:0] tx_ts_tag,
   input wire logic rx_sop_in,
   input wire logic rx_ena_in,
   output logic rx_sop_out,
   output logic rx_ts_valid,
   output logic [79:0] rx_ts
);
   localparam logic [10:0] TRIM_DEFAULT = RATE_50G ? (TC_BUILD ? TRIM_50G_TC : TRIM_50G_OC) :
      WIDE_256 ? (TC_BUILD ? TRIM_40G_WIDE_TC : TRIM_40G_WIDE_OC) :
      (TC_BUILD ? TRIM_40G_TC : TRIM_40G_OC);
   localparam int IDX_W = 11;

   // Adds nanoseconds in the active format
   function automatic logic [79:0] ts_add(logic [79:0] t, logic [15:0] ns, logic cf);
      logic [32:0] s;
      logic [63:0] c;
      s = {1'b0, t[31:0]} + {17'h0, ns};
      c = t[63:0] + {32'h0, ns, 16'h0};
      if (cf)
         ts_add = {16'h0, c}; // [RL2] [RL25]
      else if (s >= NS_PER_SEC) // [RL1]
         ts_add = {t[79:32] + 48'h1, 32'(s - NS_PER_SEC)};
      else
         ts_add = {t[79:32], s[31:0]};
   endfunction

   // Incremental one's complement update, old and new as five words
   function automatic logic [15:0] csum_update(logic [15:0] hc, logic [79:0] oldv,
                                               logic [79:0] newv);
      logic [19:0] acc;
      acc = {4'h0, ~hc};
      for (int i = 0; i < 5; i++)
      begin
         acc = acc + {4'h0, ~oldv[16*i +: 16]} + {4'h0, newv[16*i +: 16]};
      end
      acc = {4'h0, acc[15:0]} + {16'h0, acc[19:16]};
      acc = {4'h0, acc[15:0]} + {16'h0, acc[19:16]};
      csum_update = (~acc[15:0] == 16'h0) ? 16'hFFFF : ~acc[15:0];
   endfunction

   logic [1:0] ctrl_q;
   logic [10:0] trim_q;
   logic [15:0] tx_cnt_q, rx_cnt_q;
   logic pready_q, pslverr_q;
   logic [31:0] prdata_q;
   byte_beat_type line_q [DELAY];
   logic [IDX_W-1:0] in_idx_q, out_idx_q;
   tx_cmd_type in_cmd_q, out_cmd_q;
   logic [79:0] ts1_q, old_field_q;
   logic [15:0] old_csum_q;
   logic [31:0] crc_q;
   logic [1:0] fcs_cnt_q;
   byte_beat_type tx_out_q;
   logic tx_ts_valid_q;
   logic [79:0] tx_ts_q;
   logic [15:0] tx_ts_tag_q;
   logic rx_sop_q, rx_ts_valid_q;
   logic [79:0] rx_ts_q;

   logic cf_mode, apb_setup, apb_done, hit;
   logic [31:0] rd_data;
   logic in_first, out_first, one_step, two_step, tail;
   logic [IDX_W-1:0] in_idx, out_idx;
   tx_cmd_type icmd, ocmd;
   logic [3:0] flen;
   logic [79:0] new_field, old_use;
   logic [15:0] csum_new;
   logic [7:0] mod_byte, out_byte;
   logic [31:0] crc_next;
   byte_beat_type tap;

   // Register access
   assign cf_mode = !TOD_FORMAT || ctrl_q[CTRL_TC_MODE_BIT];
   assign apb_setup = psel && penable && !pready_q;
   assign apb_done = psel && penable && pready_q && pwrite;

   always_comb
   begin
      hit = 1'b1;
      rd_data = 32'h0;
      unique case (paddr)
         REG_CTRL: rd_data = {30'h0, ctrl_q};
         REG_TRIM: rd_data = {21'h0, trim_q};
         REG_STAT: rd_data = {rx_cnt_q, tx_cnt_q};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
      end
      else
      begin
         pready_q <= apb_setup;
         pslverr_q <= apb_setup && !hit;
         if (apb_setup)
         begin
            prdata_q <= pwrite ? 32'h0 : rd_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_q <= {TC_BUILD, CTRL_ONE_STEP_RESET};
         trim_q <= TRIM_DEFAULT; // [RL5] [RL6] [RL7] [RL8]
      end
      else if (apb_done)
      begin
         if (paddr == REG_CTRL)
            ctrl_q <= pwdata[1:0];
         if (paddr == REG_TRIM)
            trim_q <= pwdata[TRIM_W-1:0]; // [RL5]
      end
   end

   // Input side: delay line, frame context and field collection
   assign in_first = tx_in.valid && tx_in.sop;
   assign in_idx = in_first ? '0 : in_idx_q;
   assign icmd = in_first ? tx_cmd_in : in_cmd_q;
   assign flen = cf_mode ? CF_FIELD_LEN : TOD_FIELD_LEN;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < DELAY; i++)
            line_q[i] <= '0;
      end
      else
      begin
         line_q[0] <= tx_in;
         for (int i = 1; i < DELAY; i++)
            line_q[i] <= line_q[i-1];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         in_idx_q <= '0;
         in_cmd_q <= '0;
         ts1_q <= '0;
         old_field_q <= '0;
         old_csum_q <= '0;
      end
      else if (tx_in.valid)
      begin
         in_idx_q <= (&in_idx) ? in_idx : in_idx + 1'b1;
         if (in_first)
         begin
            in_cmd_q <= tx_cmd_in; // [RL9] [RL23]
            ts1_q <= ts_add(timer, {5'h0, trim_q}, cf_mode); // [RL5] [RL25] [RL3]
            old_field_q <= '0;
         end
         else
         begin
            if (in_idx >= IDX_W'(icmd.ts_offset) && in_idx < IDX_W'(icmd.ts_offset) + IDX_W'(flen))
               old_field_q <= {old_field_q[71:0], tx_in.data};
            if (in_idx == IDX_W'(icmd.csum_offset))
               old_csum_q[15:8] <= tx_in.data;
            if (in_idx == IDX_W'(icmd.csum_offset) + 1'b1)
               old_csum_q[7:0] <= tx_in.data;
         end
      end
   end

   // Output side: field rewrite, checksum and frame check sequence
   assign tap = line_q[DELAY-1];
   assign out_first = tap.valid && tap.sop;
   assign out_idx = out_first ? '0 : out_idx_q;
   assign ocmd = out_first ? in_cmd_q : out_cmd_q;
   assign one_step = ocmd.op == OP_ONE_STEP && ctrl_q[CTRL_ONE_STEP_BIT]; // [RL14] [RL23]
   assign two_step = ocmd.op == OP_TWO_STEP; // [RL14]
   assign old_use = cf_mode ? {16'h0, old_field_q[63:0]} : old_field_q;
   assign new_field = cf_mode ? {16'h0, old_field_q[63:0] + ts1_q[63:0]} : ts1_q; // [RL13] [RL12]
   assign csum_new = csum_update(old_csum_q, old_use, new_field); // [RL15] [RL18] [RL19]

   always_comb
   begin
      int sel;
      sel = 0;
      mod_byte = tap.data;
      tail = tap.eop;
      for (int i = 1; i < FCS_LEN; i++)
         tail = tail | line_q[DELAY-1-i].eop;
      if (one_step)
      begin
         if (out_idx >= IDX_W'(ocmd.ts_offset) && out_idx < IDX_W'(ocmd.ts_offset) + IDX_W'(flen))
         begin
            sel = int'(flen) - 1 - int'(out_idx - IDX_W'(ocmd.ts_offset));
            mod_byte = new_field[sel*8 +: 8]; // [RL12] [RL13]
         end
         if (ocmd.udp_upd && out_idx == IDX_W'(ocmd.csum_offset))
            mod_byte = csum_new[15:8]; // [RL15]
         if (ocmd.udp_upd && out_idx == IDX_W'(ocmd.csum_offset) + 1'b1)
            mod_byte = csum_new[7:0]; // [RL15]
      end
      out_byte = mod_byte;
      if (one_step && tail)
         out_byte = 8'(~crc_q >> {fcs_cnt_q, 3'h0}); // [RL16]
   end

   crc32_byte crc_step (
      .crc_in(out_first ? CRC_INIT : crc_q),
      .data_in(mod_byte),
      .crc_out(crc_next)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_idx_q <= '0;
         out_cmd_q <= '0;
         crc_q <= CRC_INIT;
         fcs_cnt_q <= '0;
         tx_out_q <= '0;
      end
      else
      begin
         tx_out_q <= '{valid: tap.valid, sop: tap.sop, eop: tap.eop, data: out_byte};
         if (tap.valid)
         begin
            out_idx_q <= (&out_idx) ? out_idx : out_idx + 1'b1;
            if (out_first)
               out_cmd_q <= in_cmd_q;
            if (!tail)
               crc_q <= crc_next; // [RL16]
            fcs_cnt_q <= (tail && !tap.eop) ? fcs_cnt_q + 1'b1 : 2'h0;
         end
      end
   end

   // Egress stamp report, one per stamped frame in line order
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ts_valid_q <= 1'b0;
         tx_ts_q <= '0;
         tx_ts_tag_q <= '0;
         tx_cnt_q <= '0;
      end
      else
      begin
         tx_ts_valid_q <= out_first && (one_step || two_step); // [RL26]
         if (out_first && one_step)
         begin
            tx_ts_q <= ts1_q; // [RL10] [RL11]
            tx_ts_tag_q <= ocmd.tag; // [RL24]
         end
         else if (out_first && two_step)
         begin
            tx_ts_q <= ts_add(timer, REF_CORR_NS, cf_mode); // [RL4] [RL17] [RL25]
            tx_ts_tag_q <= ocmd.tag; // [RL17] [RL24]
         end
         if (out_first && (one_step || two_step))
            tx_cnt_q <= tx_cnt_q + 1'b1;
      end
   end

   // Ingress stamps at every start of packet
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_sop_q <= 1'b0;
         rx_ts_valid_q <= 1'b0;
         rx_ts_q <= '0;
         rx_cnt_q <= '0;
      end
      else
      begin
         rx_sop_q <= rx_sop_in;
         rx_ts_valid_q <= rx_sop_in && rx_ena_in; // [RL22] [RL21]
         if (rx_sop_in)
            rx_ts_q <= timer; // [RL20] [RL21]
         if (rx_sop_in && rx_ena_in)
            rx_cnt_q <= rx_cnt_q + 1'b1;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign tx_out = tx_out_q;
   assign tx_ts_valid = tx_ts_valid_q;
   assign tx_ts = tx_ts_q;
   assign tx_ts_tag = tx_ts_tag_q;
   assign rx_sop_out = rx_sop_q;
   assign rx_ts_valid = rx_ts_valid_q;
   assign rx_ts = rx_ts_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_two_step_start;
      out_first && two_step;
   endsequence
   sequence s_one_step_start;
      out_first && one_step;
   endsequence

   a_rx_stamp_sop: assert property (rx_ts_valid_q == $past(rx_sop_in && rx_ena_in)) // [RL22]
      else $error("ingress stamp valid not tied to start and enable");
   a_rx_stamp_value: assert property (rx_sop_in |=> rx_ts_q == $past(timer)) // [RL20]
      else $error("ingress stamp not the timer at start");
   a_two_step_tag: assert property (s_two_step_start |=> tx_ts_valid_q && tx_ts_tag_q == $past(ocmd.tag)) // [RL17]
      else $error("two-step stamp or tag missing");
   a_one_step_ret: assert property (s_one_step_start |=> tx_ts_valid_q && tx_ts_q == $past(ts1_q)) // [RL10]
      else $error("one-step stamp not returned");
   a_stamp_pulse: assert property (tx_ts_valid_q |=> !tx_ts_valid_q) // [RL26]
      else $error("stamp valid longer than one cycle");
   a_cf_upper_zero: assert property (tx_ts_valid_q && cf_mode |-> tx_ts_q[79:64] == 16'h0) // [RL11]
      else $error("correction stamp upper bits not zero");
   a_tod_ns_range: assert property (tx_ts_valid_q && !cf_mode |-> tx_ts_q[31:0] < NS_PER_SEC[31:0]) // [RL1]
      else $error("nanoseconds out of range");
   a_plain_pass: assert property ($past(tap.valid && !one_step) |-> tx_out_q.data == $past(tap.data)) // [RL14]
      else $error("unmodified frame byte changed");
   a_fcs_first: assert property (tap.valid && one_step && tail && fcs_cnt_q == 2'h0 |=> tx_out_q.data == ~$past(crc_q[7:0])) // [RL16]
      else $error("frame check byte wrong");
   a_trim_write: assert property (apb_done && paddr == REG_TRIM |=> trim_q == $past(pwdata[10:0])) // [RL5]
      else $error("latency trim not written");
endmodule

//--- tb/client_model.sv
/*
 Client packet source: sends one contiguous egress frame per start pulse.
 Assumes start is raised only while busy is low.
*/
`timescale 1ns/1ps
module client_model
   import ptp_ts_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire tx_cmd_type cmd,
   input wire logic [7:0] len,
   output byte_beat_type tx_in,
   output tx_cmd_type tx_cmd_in,
   output logic busy
);
   logic [7:0] idx_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         idx_q <= 8'h00;
         busy <= 1'b0;
         tx_in <= '0;
         tx_cmd_in <= '0;
      end
      else if (start || (busy && idx_q != len))
      begin
         // Frame without gaps, command only good in first cycle
         tx_in.valid <= 1'b1;
         tx_in.sop <= (idx_q == 8'h00);
         tx_in.eop <= (idx_q == len - 8'h01);
         // Checksum frames carry zero stamp bytes
         tx_in.data <= (cmd.udp_upd && idx_q >= cmd.ts_offset && idx_q < cmd.ts_offset + 8'h0A) ?
            8'h00 : 8'h30 + idx_q;
         tx_cmd_in <= (idx_q == 8'h00) ? cmd : tx_cmd_type'(~cmd);
         idx_q <= idx_q + 8'h01;
         busy <= 1'b1;
      end
      else
      begin
         // Idle stream inverts the data byte every cycle
         tx_in.valid <= 1'b0;
         tx_in.sop <= 1'b0;
         tx_in.eop <= 1'b0;
         tx_in.data <= ~tx_in.data;
         idx_q <= 8'h00;
         busy <= 1'b0;
      end
   end
endmodule

//--- tb/tb_top.sv
/*
 Self-checking bench: APB register access, egress frames of each
 operation code, ingress start markers.
 Assumes the design package, design and client model compile first.
*/
`timescale 1ns/1ps
module tb_top import ptp_ts_pkg::*; ;
   localparam int DLY = 16;
   localparam int FLEN = 32;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [79:0] timer = {48'h5, 32'h64};
   byte_beat_type tx_in;
   tx_cmd_type tx_cmd_in;
   tx_cmd_type cmd = '0;
   byte_beat_type tx_out;
   logic tx_ts_valid;
   logic [79:0] tx_ts;
   logic [15:0] tx_ts_tag;
   logic rx_sop_in = 1'b0;
   logic rx_ena_in = 1'b0;
   logic rx_sop_out;
   logic rx_ts_valid;
   logic [79:0] rx_ts;
   logic start = 1'b0;
   logic busy;
   logic [7:0] outq [$];
   logic [79:0] sop_t, ts_seen, rx_seen, st, rt;
   logic [15:0] tag_seen;
   logic [31:0] rd;
   logic err;
   logic [1:0] quiet [3] = '{OP_NONE, 2'h3, OP_ONE_STEP};
   int ts_cnt = 0;
   int rx_cnt = 0;
   int cycles = 0;
   int n;
   int mismatches = 0;
   int samples_checked = 0;

   always #5 pclk = ~pclk;

   client_model u_client (.pclk(pclk), .presetn(presetn), .start(start), .cmd(cmd),
      .len(8'(FLEN)), .tx_in(tx_in), .tx_cmd_in(tx_cmd_in), .busy(busy));

   ptp_frame_timestamping #(.DELAY(DLY), .TOD_FORMAT(1'b1), .RATE_50G(1'b1),
      .WIDE_256(1'b0), .TC_BUILD(1'b0)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer(timer), .tx_in(tx_in),
      .tx_cmd_in(tx_cmd_in), .tx_out(tx_out), .tx_ts_valid(tx_ts_valid), .tx_ts(tx_ts),
      .tx_ts_tag(tx_ts_tag), .rx_sop_in(rx_sop_in), .rx_ena_in(rx_ena_in),
      .rx_sop_out(rx_sop_out), .rx_ts_valid(rx_ts_valid), .rx_ts(rx_ts));

   task automatic tally_and_finish;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [79:0] seen, input logic [79:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
      output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (k == 50)
         mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic send_frame(input logic [1:0] op, input logic [15:0] tag, input logic u);
      int k;
      k = 0;
      outq.delete();
      cmd <= '{op, u, 8'h04, 8'h01, tag};
      start <= 1'b1;
      @(posedge pclk);
      start <= 1'b0;
      while (outq.size() < FLEN && k < 200)
      begin
         @(posedge pclk);
         k++;
      end
      repeat (2) @(posedge pclk);
   endtask

   task automatic check_bytes(input logic stamped, input logic [79:0] s, input logic u,
      input int f);
      logic [7:0] e [FLEN];
      logic [31:0] c;
      logic [19:0] a;
      for (int i = 0; i < FLEN; i++)
         e[i] = (stamped && i >= 4 && i < 4 + f) ? s[8 * (f + 3 - i) +: 8] : 8'h30 + 8'(i);
      // Incremental checksum: old stamp words zero, old checksum bytes 1 and 2
      a = {4'h0, ~16'h3132};
      for (int w = 0; w < 5; w++)
         a = a + 20'h0FFFF + {4'h0, s[16 * w +: 16]};
      a = {4'h0, a[15:0]} + {16'h0, a[19:16]};
      a = {4'h0, a[15:0]} + {16'h0, a[19:16]};
      if (u)
      begin
         e[1] = (a[15:0] == 16'hFFFF) ? 8'hFF : ~a[15:8];
         e[2] = (a[15:0] == 16'hFFFF) ? 8'hFF : ~a[7:0];
      end
      c = 32'hFFFF_FFFF;
      for (int i = 0; i < FLEN - 4; i++)
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ({32{c[0] ^ e[i][b]}} & 32'hEDB8_8320);
      for (int i = 0; i < 4 && stamped; i++)
         e[FLEN - 4 + i] = ~c[8 * i +: 8];
      check(80'(outq.size()), 80'(FLEN));
      for (int i = 0; i < FLEN; i++)
         check(80'(outq[i]), 80'(e[i]));
   endtask

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      timer <= timer + 80'hA;
      if (tx_in.valid && tx_in.sop)
         sop_t <= timer;
      if (tx_out.valid)
         outq.push_back(tx_out.data);
      if (tx_ts_valid)
      begin
         ts_seen <= tx_ts;
         tag_seen <= tx_ts_tag;
         ts_cnt <= ts_cnt + 1;
         check(80'(tx_out.sop), 80'h1);
      end
      if (rx_ts_valid)
      begin
         rx_seen <= rx_ts;
         rx_cnt <= rx_cnt + 1;
         check(80'(rx_sop_out), 80'h1);
      end
      if (cycles == 5000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb_xfer(REG_CTRL, 1'b0, 32'h0, rd, err);
      check(80'(rd), 80'h1);
      apb_xfer(REG_TRIM, 1'b0, 32'h0, rd, err);
      check(80'(rd), 80'h1C2);
      apb_xfer(12'h0FC, 1'b0, 32'h0, rd, err);
      check(80'({err, rd}), 80'h1_0000_0000);
      apb_xfer(REG_TRIM, 1'b1, 32'h0000_07FF, rd, err);
      apb_xfer(REG_TRIM, 1'b0, 32'h0, rd, err);
      check(80'(rd), 80'h7FF);
      send_frame(OP_ONE_STEP, 16'hA5A5, 1'b1);
      st = {sop_t[79:32], sop_t[31:0] + 32'h7FF};
      check(ts_seen, st);
      check(80'(tag_seen), 80'hA5A5);
      check_bytes(1'b1, st, 1'b1, 10);
      send_frame(OP_TWO_STEP, 16'h1234, 1'b0);
      check(ts_seen, {sop_t[79:32], sop_t[31:0] + 32'(10 * DLY + 20)});
      check(80'(tag_seen), 80'h1234);
      check_bytes(1'b0, st, 1'b0, 10);
      n = ts_cnt;
      for (int k = 0; k < 3; k++)
      begin
         if (k == 2)
            apb_xfer(REG_CTRL, 1'b1, 32'h0, rd, err);
         send_frame(quiet[k], 16'h0F0F, 1'b0);
         check(80'(ts_cnt), 80'(n));
         check_bytes(1'b0, st, 1'b0, 10);
      end
      rx_sop_in <= 1'b1;
      rx_ena_in <= 1'b1;
      @(posedge pclk);
      rt = timer;
      rx_sop_in <= 1'b0;
      repeat (3) @(posedge pclk);
      check(80'(rx_cnt), 80'h1);
      check(rx_seen, rt);
      rx_ena_in <= 1'b0;
      rx_sop_in <= 1'b1;
      @(posedge pclk);
      rx_sop_in <= 1'b0;
      repeat (3) @(posedge pclk);
      check(80'(rx_cnt), 80'h1);
      apb_xfer(REG_CTRL, 1'b1, 32'h0000_0003, rd, err);
      send_frame(OP_ONE_STEP, 16'h00C3, 1'b0);
      st = {16'h0, sop_t[63:0] + 64'h0000_0000_07FF_0000};
      check(ts_seen, st);
      check(80'(tag_seen), 80'h00C3);
      check_bytes(1'b1, {16'h0, st[63:0] + 64'h3435_3637_3839_3A3B}, 1'b0, 8);
      apb_xfer(REG_STAT, 1'b0, 32'h0, rd, err);
      check(80'(rd), 80'h0001_0003);
      tally_and_finish();
   end
endmodule
